// File: shared/host_port_pkg.sv
// constants, mode codes and state types for the display host bus port
// assumes one 40 mhz system clock; host pins are sampled synchronously
package host_port_pkg;
    // system clock
    localparam int CLK_FREQ_HZ = 40000000;
    // interface select codes on {bit2, bit1, bit0}
    localparam logic [2:0] MODE_I2C = 3'h0;
    localparam logic [2:0] MODE_6800 = 3'h1;
    localparam logic [2:0] MODE_8080 = 3'h2;
    localparam logic [2:0] MODE_SPI4 = 3'h3;
    localparam logic [2:0] MODE_SPI3 = 3'h4;
    // bus byte width and serial bit counts
    localparam int BYTE_W = 8;
    localparam logic [3:0] SPI4_LAST_BIT = 4'h7;
    localparam logic [3:0] SPI3_LAST_BIT = 4'h8;
    localparam logic [3:0] I2C_LAST_BIT = 4'h7;
    // default upper six bits of the i2c slave address
    localparam logic [5:0] I2C_ADDR_HI_DEF = 6'h1e;
    // depth of the byte buffer
    localparam int BUF_DEPTH = 2;
    // reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [3:0] CNT_RST = 4'h0;
    // i2c receive states
    typedef enum logic [1:0] {
        I2C_IDLE = 2'b00,
        I2C_ADDR = 2'b01,
        I2C_CTRL = 2'b10,
        I2C_DATA = 2'b11
    } i2c_state_t;
endpackage : host_port_pkg

// File: shared/byte_stream_if.sv
// valid/ready byte stream carrying a data/command tag
// assumes both ends run on the same system clock
`timescale 1ns/1ps
`default_nettype none
interface byte_stream_if;
    logic valid;
    logic ready;
    logic [7:0] data;
    logic is_data;
    // side that offers bytes
    modport producer (output valid, output data, output is_data, input ready);
    // side that takes bytes
    modport consumer (input valid, input data, input is_data, output ready);
endinterface : byte_stream_if
`default_nettype wire

// File: logic/byte_buffer.sv
// small fifo for tagged bytes between host port and display core
// assumes a synchronous flush that empties it in one cycle
`timescale 1ns/1ps
`default_nettype none
module byte_buffer #(
    parameter int DEPTH = host_port_pkg::BUF_DEPTH
) (
    // clock and resets
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic flush,
    // fill and drain sides
    byte_stream_if.consumer fill,
    byte_stream_if.producer drain
);
    import host_port_pkg::*;
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] DEPTH_C = (PW + 1)'(DEPTH);
    localparam logic [PW-1:0] LAST_C = PW'(DEPTH - 1);

    logic [8:0] mem_ff [DEPTH];
    logic [PW-1:0] wr_ptr_ff;
    logic [PW-1:0] rd_ptr_ff;
    logic [PW:0] count_ff;
    logic do_push;
    logic do_pop;

    // honest flags straight from the occupancy count
    assign fill.ready = (count_ff != DEPTH_C);
    assign drain.valid = (count_ff != '0);
    assign {drain.is_data, drain.data} = mem_ff[rd_ptr_ff];
    assign do_push = fill.valid && fill.ready;
    assign do_pop = drain.valid && drain.ready;

    // storage, no reset needed on the payload
    always_ff @(posedge sys_clk) begin
        if (do_push) begin
            mem_ff[wr_ptr_ff] <= {fill.is_data, fill.data};
        end
    end

    // pointers and count
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else if (flush) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            count_ff <= '0;
        end else begin
            if (do_push) begin
                wr_ptr_ff <= (wr_ptr_ff == LAST_C) ? '0 : wr_ptr_ff + 1'b1;
            end
            if (do_pop) begin
                rd_ptr_ff <= (rd_ptr_ff == LAST_C) ? '0 : rd_ptr_ff + 1'b1;
            end
            if (do_push && !do_pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (do_pop && !do_push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule : byte_buffer
`default_nettype wire

// File: logic/oled_host_bus_port.sv
// host bus port of a small monochrome display driver
// assumes all host pins are synchronous to sys_clk and strobes last several clocks
`timescale 1ns/1ps
`default_nettype none
module oled_host_bus_port #(
    parameter logic [5:0] I2C_ADDR_HI = host_port_pkg::I2C_ADDR_HI_DEF
) (
    // clock and resets
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic reset_low_input,
    // interface select straps
    input wire logic interface_sel_bit0,
    input wire logic interface_sel_bit1,
    input wire logic interface_sel_bit2,
    // host control pins
    input wire logic chip_select_n,
    input wire logic data_command_select,
    input wire logic write_strobe_pin,
    input wire logic read_strobe_pin,
    // host data bus, split into three signals
    input wire logic [7:0] data_in,
    output logic [7:0] data_out,
    output logic [7:0] data_oe,
    // i2c acknowledge drive, open drain
    output logic i2c_data_out,
    output logic i2c_data_oe,
    // byte stream towards the command decoder and display memory
    output logic byte_valid,
    input wire logic byte_ready,
    output logic [7:0] byte_data,
    output logic byte_is_data,
    output logic port_busy,
    // read path from the display core
    input wire logic [7:0] read_byte,
    output logic read_done
);
    import host_port_pkg::*;

    logic soft_rst;
    logic cs_active;
    logic [2:0] mode;
    logic wr_prev_ff;
    logic rd_prev_ff;
    logic d0_prev_ff;
    logic d1_prev_ff;
    logic primed_ff;
    logic wr_rise;
    logic rd_rise;
    logic e_fall;
    logic scl_rise;
    logic scl_fall;
    logic i2c_start;
    logic i2c_stop;
    logic [7:0] shift_ff;
    logic [3:0] bit_cnt_ff;
    logic dc_bit_ff;
    logic [7:0] shift_full;
    i2c_state_t i2c_state_ff;
    i2c_state_t i2c_next_ff;
    logic co_ff;
    logic i2c_dc_ff;
    logic ack_pend_ff;
    logic ack_act_ff;
    logic ack_want_ff;
    logic i2c_byte_done;
    logic push_valid;
    logic [7:0] push_data;
    logic push_dc;
    logic nxt_read_done;
    logic read_drive;
    logic [7:0] data_out_ff;
    logic read_done_ff;

    byte_stream_if push_if ();
    byte_stream_if pop_if ();

    // level reset from the pin, acts every cycle it is held low
    assign soft_rst = !reset_low_input;
    assign cs_active = !chip_select_n;
    assign mode = {interface_sel_bit2, interface_sel_bit1, interface_sel_bit0};

    // previous pin levels for edge detection
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_prev_ff <= 1'b1;
            rd_prev_ff <= 1'b1;
            d0_prev_ff <= 1'b1;
            d1_prev_ff <= 1'b1;
            primed_ff <= 1'b0;
        end else begin
            primed_ff <= 1'b1;
            wr_prev_ff <= write_strobe_pin;
            rd_prev_ff <= read_strobe_pin;
            d0_prev_ff <= data_in[0];
            d1_prev_ff <= data_in[1];
        end
    end

    // edges, all qualified by chip select so idle-bus noise is dropped
    assign wr_rise = cs_active && write_strobe_pin && !wr_prev_ff;
    assign rd_rise = cs_active && read_strobe_pin && !rd_prev_ff;
    // enable idles low, so its fall waits for one real sample after reset
    assign e_fall = cs_active && primed_ff && !read_strobe_pin && rd_prev_ff;
    assign scl_rise = cs_active && data_in[0] && !d0_prev_ff;
    assign scl_fall = cs_active && !data_in[0] && d0_prev_ff;
    assign i2c_start = cs_active && data_in[0] && d0_prev_ff && d1_prev_ff && !data_in[1];
    assign i2c_stop = cs_active && data_in[0] && d0_prev_ff && !d1_prev_ff && data_in[1];
    assign shift_full = {shift_ff[6:0], data_in[1]};

    // 3-wire and 4-wire serial shift, msb first, d1 sampled on d0 rising
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            shift_ff <= BYTE_RST;
            bit_cnt_ff <= CNT_RST;
            dc_bit_ff <= 1'b0;
        end else if (soft_rst || !cs_active) begin
            shift_ff <= BYTE_RST;
            bit_cnt_ff <= CNT_RST;
            dc_bit_ff <= 1'b0;
        end else if (mode == MODE_SPI4 && scl_rise) begin
            shift_ff <= shift_full;
            bit_cnt_ff <= (bit_cnt_ff == SPI4_LAST_BIT) ? CNT_RST : bit_cnt_ff + 1'b1;
        end else if (mode == MODE_SPI3 && scl_rise) begin
            // first of nine bits is the data/command flag
            if (bit_cnt_ff == CNT_RST) begin
                dc_bit_ff <= data_in[1];
            end else begin
                shift_ff <= shift_full;
            end
            bit_cnt_ff <= (bit_cnt_ff == SPI3_LAST_BIT) ? CNT_RST : bit_cnt_ff + 1'b1;
        end else if (mode == MODE_I2C && (i2c_start || i2c_stop)) begin
            shift_ff <= BYTE_RST;
            bit_cnt_ff <= CNT_RST;
        end else if (mode == MODE_I2C && scl_rise && !ack_act_ff && i2c_state_ff != I2C_IDLE) begin
            shift_ff <= shift_full;
            bit_cnt_ff <= (bit_cnt_ff == I2C_LAST_BIT) ? CNT_RST : bit_cnt_ff + 1'b1;
        end
    end

    // last data bit of an i2c byte arriving this cycle
    assign i2c_byte_done = mode == MODE_I2C && scl_rise && !ack_act_ff
        && i2c_state_ff != I2C_IDLE && bit_cnt_ff == I2C_LAST_BIT;

    // i2c receiver: address match, control byte, data bytes, ack on d1 via own drive
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            i2c_state_ff <= I2C_IDLE;
            i2c_next_ff <= I2C_IDLE;
            co_ff <= 1'b0;
            i2c_dc_ff <= 1'b0;
            ack_pend_ff <= 1'b0;
            ack_act_ff <= 1'b0;
            ack_want_ff <= 1'b0;
        end else if (soft_rst || mode != MODE_I2C || !cs_active || i2c_stop) begin
            i2c_state_ff <= I2C_IDLE;
            i2c_next_ff <= I2C_IDLE;
            ack_pend_ff <= 1'b0;
            ack_act_ff <= 1'b0;
            ack_want_ff <= 1'b0;
        end else if (i2c_start) begin
            // repeated start also lands here
            i2c_state_ff <= I2C_ADDR;
            ack_pend_ff <= 1'b0;
            ack_act_ff <= 1'b0;
            ack_want_ff <= 1'b0;
        end else if (i2c_byte_done) begin
            ack_pend_ff <= 1'b1;
            case (i2c_state_ff)
                I2C_ADDR: begin
                    // write-only slave, address low bit is the pin level
                    ack_want_ff <= (shift_full == {I2C_ADDR_HI, data_command_select, 1'b0});
                    i2c_next_ff <= I2C_CTRL;
                end
                I2C_CTRL: begin
                    co_ff <= shift_full[7];
                    i2c_dc_ff <= shift_full[6];
                    ack_want_ff <= 1'b1;
                    i2c_next_ff <= I2C_DATA;
                end
                I2C_DATA: begin
                    // nack when the buffer is full so the host retries
                    ack_want_ff <= push_if.ready;
                    i2c_next_ff <= co_ff ? I2C_CTRL : I2C_DATA;
                end
                default: begin
                    ack_want_ff <= 1'b0;
                    i2c_next_ff <= I2C_IDLE;
                end
            endcase
        end else if (scl_fall && ack_pend_ff) begin
            ack_pend_ff <= 1'b0;
            ack_act_ff <= 1'b1;
        end else if (scl_fall && ack_act_ff) begin
            ack_act_ff <= 1'b0;
            i2c_state_ff <= ack_want_ff ? i2c_next_ff : I2C_IDLE;
        end
    end

    // ack pulls sda low through a pin of its own, d1 stays an input
    assign i2c_data_out = 1'b0;
    assign i2c_data_oe = ack_act_ff && ack_want_ff;

    // one source per mode feeds the buffer
    always_comb begin
        push_valid = 1'b0;
        push_data = data_in;
        push_dc = data_command_select;
        nxt_read_done = 1'b0;
        case (mode)
            MODE_8080: begin
                push_valid = wr_rise;
                nxt_read_done = rd_rise;
            end
            MODE_6800: begin
                // enable falling ends the cycle, direction from the write pin
                push_valid = e_fall && !write_strobe_pin;
                nxt_read_done = e_fall && write_strobe_pin;
            end
            MODE_SPI4: begin
                push_valid = scl_rise && bit_cnt_ff == SPI4_LAST_BIT;
                push_data = shift_full;
            end
            MODE_SPI3: begin
                push_valid = scl_rise && bit_cnt_ff == SPI3_LAST_BIT;
                push_data = shift_full;
                push_dc = dc_bit_ff;
            end
            MODE_I2C: begin
                push_valid = i2c_byte_done && i2c_state_ff == I2C_DATA;
                push_data = shift_full;
                push_dc = i2c_dc_ff;
            end
            default: begin
                push_valid = 1'b0;
            end
        endcase
        if (soft_rst) begin
            push_valid = 1'b0;
            nxt_read_done = 1'b0;
        end
    end

    assign push_if.valid = push_valid;
    assign push_if.data = push_data;
    assign push_if.is_data = push_dc;
    // parallel writes cannot be stalled on the pins, so busy warns the host
    assign port_busy = !push_if.ready;

    byte_buffer #(
        .DEPTH(BUF_DEPTH)
    ) u_buf (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .flush(soft_rst),
        .fill(push_if),
        .drain(pop_if)
    );

    assign byte_valid = pop_if.valid;
    assign byte_data = pop_if.data;
    assign byte_is_data = pop_if.is_data;
    assign pop_if.ready = byte_ready;

    // parallel read drive: 8080 while read low, 6800 while enable high and direction read
    assign read_drive = cs_active && !soft_rst
        && ((mode == MODE_8080 && !read_strobe_pin)
        || (mode == MODE_6800 && read_strobe_pin && write_strobe_pin));
    // serial modes never drive, d2 to d7 left floating
    assign data_oe = {8{read_drive}};

    // registered read byte and end-of-read pulse
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            data_out_ff <= BYTE_RST;
            read_done_ff <= 1'b0;
        end else begin
            data_out_ff <= read_byte;
            read_done_ff <= nxt_read_done;
        end
    end

    assign data_out = data_out_ff;
    assign read_done = read_done_ff;
endmodule : oled_host_bus_port
`default_nettype wire

// File: dv/oled_host_bus_port_props.sv
// checker for the display host bus port, bound to its top module
// assumes one clock and mode straps held still during transfers
`timescale 1ns/1ps
`default_nettype none
module oled_host_bus_port_props
    import host_port_pkg::*;
(
    // clock and resets
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic reset_low_input,
    // straps and host pins
    input wire logic interface_sel_bit0,
    input wire logic interface_sel_bit1,
    input wire logic interface_sel_bit2,
    input wire logic chip_select_n,
    input wire logic data_command_select,
    input wire logic write_strobe_pin,
    input wire logic read_strobe_pin,
    input wire logic [7:0] data_in,
    input wire logic [7:0] data_out,
    input wire logic [7:0] data_oe,
    input wire logic i2c_data_out,
    input wire logic i2c_data_oe,
    // byte stream and read path
    input wire logic byte_valid,
    input wire logic byte_ready,
    input wire logic [7:0] byte_data,
    input wire logic byte_is_data,
    input wire logic port_busy,
    input wire logic [7:0] read_byte,
    input wire logic read_done
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    logic [2:0] mode;
    logic live_ff, cs_ff, sel, m80, m68;
    // first edge after reset sees stale pins, so it is skipped
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            live_ff <= 1'b0;
            cs_ff <= 1'b1;
        end else begin
            live_ff <= 1'b1;
            cs_ff <= chip_select_n;
        end
    end
    // selected for two samples and out of pin reset
    assign mode = {interface_sel_bit2, interface_sel_bit1, interface_sel_bit0};
    assign sel = live_ff && !chip_select_n && !cs_ff && reset_low_input;
    assign m80 = sel && mode == MODE_8080;
    assign m68 = sel && mode == MODE_6800;
    AST_CS_QUIET: assert property ($rose(byte_valid) |-> !$past(chip_select_n))
        else $error("byte pushed while deselected");
    AST_WR_CAPTURE: assert property (m80 && $rose(write_strobe_pin) && !byte_valid |=> byte_valid
        && byte_data == $past(data_in) && byte_is_data == $past(data_command_select))
        else $error("8080 write not captured");
    AST_RD_DRIVE: assert property (mode == MODE_8080 && !chip_select_n && !read_strobe_pin
        && reset_low_input |-> data_oe == 8'hff)
        else $error("bus not driven during read");
    AST_OE_CAUSE: assert property (data_oe != 8'h00 |-> !chip_select_n && (mode == MODE_8080 ?
        !read_strobe_pin : mode == MODE_6800 && read_strobe_pin && write_strobe_pin))
        else $error("bus driven outside a read");
    AST_RD_DONE: assert property (m80 && $rose(read_strobe_pin) |=> read_done)
        else $error("read end not reported");
    AST_M68_CAPTURE: assert property (m68 && $fell(read_strobe_pin) && !write_strobe_pin && !byte_valid
        |=> byte_valid && byte_data == $past(data_in) && byte_is_data == $past(data_command_select))
        else $error("6800 write not captured");
    AST_PIN_RESET: assert property (!reset_low_input |=> !byte_valid && !i2c_data_oe)
        else $error("pin reset left state");
    AST_ACK_MODE: assert property (i2c_data_oe |-> mode == MODE_I2C && !i2c_data_out)
        else $error("ack outside i2c mode");
endmodule : oled_host_bus_port_props
bind oled_host_bus_port oled_host_bus_port_props u_props (.sys_clk, .sys_rst, .reset_low_input,
    .interface_sel_bit0, .interface_sel_bit1, .interface_sel_bit2, .chip_select_n, .data_command_select,
    .write_strobe_pin, .read_strobe_pin, .data_in, .data_out, .data_oe, .i2c_data_out, .i2c_data_oe,
    .byte_valid, .byte_ready, .byte_data, .byte_is_data, .port_busy, .read_byte, .read_done);
`default_nettype wire

// File: dv/mpu_host_model.sv
// host model: 8080, 6800, serial and i2c cycles on the port's pins
// assumes the bench calls one task at a time
`timescale 1ns/1ps
`default_nettype none
module mpu_host_model (
    // clock and port answers
    input wire logic sys_clk,
    input wire logic i2c_data_out,
    input wire logic i2c_data_oe,
    input wire logic [7:0] data_oe,
    input wire logic [7:0] data_out,
    // host pins
    output logic chip_select_n,
    output logic data_command_select,
    output logic write_strobe_pin,
    output logic read_strobe_pin,
    output logic [7:0] data_in
);
    logic [7:0] bus_ff = 8'hff;
    // sda has a pull-up; while enabled the port's drive level wins over it
    assign data_in = {bus_ff[7:2], bus_ff[1] & (i2c_data_out | ~i2c_data_oe), bus_ff[0]};
    initial begin
        chip_select_n = 1'b1;
        data_command_select = 1'b0;
        write_strobe_pin = 1'b1;
        read_strobe_pin = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : tick
    // idle levels: 8080 strobes high, 6800 enable low
    task automatic idle(input logic m68);
        @(posedge sys_clk);
        write_strobe_pin <= 1'b1;
        read_strobe_pin <= ~m68;
    endtask : idle
    // one write, or a 6800 read when rw is high
    task automatic par_wr(input logic m68, sel, rw, dc, input logic [7:0] b);
        @(posedge sys_clk);
        chip_select_n <= ~sel;
        data_command_select <= dc;
        bus_ff <= b;
        write_strobe_pin <= m68 ? rw : 1'b0;
        read_strobe_pin <= 1'b1;
        tick(3);
        if (m68) read_strobe_pin <= 1'b0;
        else write_strobe_pin <= 1'b1;
        tick(3);
        chip_select_n <= 1'b1;
        bus_ff <= ~b; // old value is no longer held
    endtask : par_wr
    // 8080 read; samples the port's drive mid-strobe
    task automatic par_rd(output logic [7:0] oe, output logic [7:0] d);
        @(posedge sys_clk);
        chip_select_n <= 1'b0;
        read_strobe_pin <= 1'b0;
        tick(2);
        @(negedge sys_clk);
        oe = data_oe;
        d = data_out;
        @(posedge sys_clk);
        read_strobe_pin <= 1'b1;
        tick(3);
        chip_select_n <= 1'b1;
    endtask : par_rd
    // serial byte msb first; 3-wire form sends dc first
    task automatic spi_byte(input logic three, dc, input logic [7:0] b);
        logic [8:0] bits;
        bits = {dc, b};
        @(posedge sys_clk);
        chip_select_n <= 1'b0;
        data_command_select <= dc;
        for (int i = three ? 8 : 7; i >= 0; i--) begin
            bus_ff <= {6'h3f, bits[i], 1'b0};
            tick(2);
            bus_ff[0] <= 1'b1;
            tick(2);
        end
        chip_select_n <= 1'b1;
    endtask : spi_byte
    task automatic i2c_start(input logic sa0);
        @(posedge sys_clk);
        chip_select_n <= 1'b0;
        data_command_select <= sa0;
        bus_ff[1:0] <= 2'b11;
        tick(2);
        bus_ff[1] <= 1'b0;
        tick(2);
    endtask : i2c_start
    // eight bits, then sda released for the ack slot
    task automatic i2c_byte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bus_ff[1:0] <= {b[i], 1'b0};
            tick(2);
            bus_ff[0] <= 1'b1;
            tick(2);
        end
        bus_ff[1:0] <= 2'b10;
        tick(3);
        bus_ff[0] <= 1'b1;
        @(negedge sys_clk);
        ack = ~data_in[1];
        tick(2);
    endtask : i2c_byte
    task automatic i2c_stop();
        bus_ff[1:0] <= 2'b00;
        tick(2);
        bus_ff[0] <= 1'b1;
        tick(2);
        bus_ff[1] <= 1'b1;
        tick(2);
        chip_select_n <= 1'b1;
    endtask : i2c_stop
endmodule : mpu_host_model
`default_nettype wire

// File: dv/oled_host_bus_port_tb.sv
// self-checking bench for the display host bus port
// assumes the host model drives the pins and the bench is the byte consumer
`timescale 1ns/1ps
`default_nettype none
`define CHECK(a, b) begin samples_checked++; if ((a) !== (b)) begin mismatches++; $display("ERROR %0t: got %h want %h", $time, a, b); end end
module oled_host_bus_port_tb;
    import host_port_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic reset_low_input = 1'b1;
    logic byte_ready = 1'b1;
    logic [2:0] mode = MODE_8080;
    logic [7:0] read_byte = 8'h5a;
    logic cs_n, dc, wr, rd, ack_oe, ack_d, byte_valid, byte_is_data, port_busy, read_done;
    logic [7:0] data_in, data_out, data_oe, byte_data;
    logic [8:0] got_q[$];
    int mismatches = 0;
    int samples_checked = 0;
    int reads_seen = 0;
    always #12.5 sys_clk = ~sys_clk;
    oled_host_bus_port u_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reset_low_input(reset_low_input),
        .interface_sel_bit0(mode[0]), .interface_sel_bit1(mode[1]), .interface_sel_bit2(mode[2]),
        .chip_select_n(cs_n), .data_command_select(dc), .write_strobe_pin(wr), .read_strobe_pin(rd),
        .data_in(data_in), .data_out(data_out), .data_oe(data_oe), .i2c_data_out(ack_d), .i2c_data_oe(ack_oe),
        .byte_valid(byte_valid), .byte_ready(byte_ready), .byte_data(byte_data), .byte_is_data(byte_is_data),
        .port_busy(port_busy), .read_byte(read_byte), .read_done(read_done));
    mpu_host_model host (.sys_clk(sys_clk), .i2c_data_out(ack_d), .i2c_data_oe(ack_oe), .data_oe(data_oe),
        .data_out(data_out),
        .chip_select_n(cs_n), .data_command_select(dc), .write_strobe_pin(wr), .read_strobe_pin(rd),
        .data_in(data_in));
    // consumer side: record each byte handed over and count read-end pulses
    always @(negedge sys_clk) begin
        if (byte_valid === 1'b1 && byte_ready === 1'b1) got_q.push_back({byte_is_data, byte_data});
        if (read_done === 1'b1) reads_seen++;
    end
    // bounded wait for the next byte, then compare it
    task automatic take(input logic d, input logic [7:0] b);
        logic [8:0] v;
        v = 'x;
        repeat (40) if (got_q.size() == 0) @(negedge sys_clk);
        if (got_q.size() > 0) v = got_q.pop_front();
        `CHECK(v, {d, b})
    endtask : take
    task automatic none();
        repeat (8) @(negedge sys_clk);
        `CHECK(got_q.size(), 0)
        got_q.delete();
    endtask : none
    task automatic set_mode(input logic [2:0] m, input logic m68);
        @(posedge sys_clk) mode <= m;
        host.idle(m68);
    endtask : set_mode
    task automatic t_8080();
        logic [7:0] oe, d;
        set_mode(MODE_8080, 1'b0);
        host.par_wr(1'b0, 1'b1, 1'b0, 1'b0, 8'h3c);
        host.par_wr(1'b0, 1'b1, 1'b0, 1'b1, 8'ha7);
        take(1'b0, 8'h3c);
        take(1'b1, 8'ha7);
        host.par_rd(oe, d);
        `CHECK(oe, 8'hff)
        `CHECK(d, 8'h5a)
        `CHECK(data_oe, 8'h00)
        `CHECK(reads_seen, 1)
        host.par_wr(1'b0, 1'b0, 1'b0, 1'b1, 8'h11);
        none();
        $display("test 8080 done");
    endtask : t_8080
    task automatic t_stall();
        @(posedge sys_clk) byte_ready <= 1'b0;
        host.par_wr(1'b0, 1'b1, 1'b0, 1'b1, 8'h01);
        host.par_wr(1'b0, 1'b1, 1'b0, 1'b1, 8'h02);
        host.par_wr(1'b0, 1'b1, 1'b0, 1'b1, 8'h03);
        `CHECK(port_busy, 1'b1)
        @(posedge sys_clk) byte_ready <= 1'b1;
        take(1'b1, 8'h01);
        take(1'b1, 8'h02);
        `CHECK(port_busy, 1'b0)
        none();
        // a held byte must not survive the pin reset
        @(posedge sys_clk) byte_ready <= 1'b0;
        host.par_wr(1'b0, 1'b1, 1'b0, 1'b0, 8'h44);
        @(posedge sys_clk) reset_low_input <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_low_input <= 1'b1;
        byte_ready <= 1'b1;
        none();
        $display("test stall done");
    endtask : t_stall
    task automatic t_6800();
        set_mode(MODE_6800, 1'b1);
        host.par_wr(1'b1, 1'b1, 1'b0, 1'b1, 8'h81);
        take(1'b1, 8'h81);
        host.par_wr(1'b1, 1'b1, 1'b1, 1'b0, 8'h22);
        `CHECK(reads_seen, 2)
        none();
        $display("test 6800 done");
    endtask : t_6800
    task automatic t_serial();
        set_mode(MODE_SPI4, 1'b0);
        host.spi_byte(1'b0, 1'b1, 8'hc3);
        take(1'b1, 8'hc3);
        set_mode(MODE_SPI3, 1'b0);
        host.spi_byte(1'b1, 1'b0, 8'h96);
        take(1'b0, 8'h96);
        `CHECK(data_oe, 8'h00)
        $display("test serial done");
    endtask : t_serial
    task automatic t_i2c();
        logic a;
        set_mode(MODE_I2C, 1'b0);
        host.i2c_start(1'b1);
        host.i2c_byte({I2C_ADDR_HI_DEF, 2'b10}, a);
        `CHECK(a, 1'b1)
        // one command byte under a set continuation bit, then a data stream
        host.i2c_byte(8'h80, a);
        host.i2c_byte(8'h5e, a);
        host.i2c_byte(8'h40, a);
        host.i2c_byte(8'he1, a);
        `CHECK(a, 1'b1)
        host.i2c_stop();
        take(1'b0, 8'h5e);
        take(1'b1, 8'he1);
        host.i2c_start(1'b1);
        host.i2c_byte({I2C_ADDR_HI_DEF, 2'b00}, a);
        `CHECK(a, 1'b0)
        host.i2c_stop();
        none();
        $display("test i2c done");
    endtask : t_i2c
    task automatic conclude();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (8) @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        t_8080();
        t_stall();
        t_6800();
        t_serial();
        t_i2c();
        conclude();
    end
    // the tests need a few hundred cycles; this cuts a hang short
    initial begin
        repeat (20000) @(posedge sys_clk);
        mismatches++;
        conclude();
    end
endmodule : oled_host_bus_port_tb
`default_nettype wire
